// file: rtl/pps_pin_select.sv
`timescale 1ns/1ps
// Summary of operation
// - Power-on reset makes all three converter pins general-purpose outputs.
// - Converter duty registers need no initialisation at power-on reset.
// - Clock stop returns converter pins to general-purpose, driving the latch.
// - Clock stop leaves every duty data register unchanged.
// - CE reset and halt keep pin states; converter pins keep pulsing.
// - Clock port offers variable-duty and variable-frequency output modes.
// - Variable-duty mode has 64 duty settings.
// - Variable-frequency mode has 64 frequency settings.
// - Clock port and frequency counter never run at the same time.
// - Clock pin select: 0 general-purpose output, 1 clock port output while clock_port_en is 1, else the latch.
// - Pin-mode register holds one select bit per converter pin.
// - Pin-mode register is read/write at register-file address 13H.
// - Clock port setting is loaded at peripheral address 20H.
// - A basic clock of 18 kHz drives both port modes.
// - Duty mode: high while count below x plus 2, period 67 counts.
// - Frequency mode: square wave at 18/(2(x+2)) kHz, 50% duty.
// - Counter mode register at 12H chooses clock port or counter use.
// - Converter select bit: 0 general-purpose output, 1 converter output.
module pps_pin_select
    import pps_pkg::*;
#(
    parameter int BASE_DIV = BASE_DIV_CYC
) (
    // Clock and power-on reset.
    input wire logic mclk,
    input wire logic sys_rst,
    // Standby events from the controller.
    input wire logic clk_stop,
    input wire logic ce_reset,
    input wire logic halt,
    // Register file port.
    input wire pps_req_t rf_req,
    output logic [3:0] rf_rdata,
    // Peripheral port through the data buffer.
    input wire pps_req_t pa_req,
    output logic [7:0] pa_rdata,
    // Counter use chosen by the counter mode register, 1 for clock port.
    input wire logic clock_port_en,
    // Port output latches and converter waveforms.
    input wire logic [3:0] port_latch,
    input wire logic [2:0] conv_pwm,
    // Pins.
    output logic [2:0] conv_out,
    output logic clock_port_pin
);
    // The basic tick must leave at least two idle cycles between ticks.
    if (BASE_DIV < 3 || BASE_DIV > 65535) begin : g_chk
        $error("BASE_DIV must lie between 3 and 65535");
    end

    localparam logic [15:0] DIV_LAST = 16'(BASE_DIV - 1);

    pps_state_t s_r;
    pps_state_t s_nxt;
    logic tick;
    logic sg_mode;
    logic [6:0] x_val;
    logic [6:0] limit;
    logic wave;

    assign tick = (s_r.div == DIV_LAST);
    assign sg_mode = s_r.setting[SET_MODE_BIT];
    assign x_val = {1'b0, s_r.setting[SET_X_LSB +: 6]};
    assign limit = sg_mode ? x_val + PORT_OFFSET - 7'd1 : VDP_LAST_COUNT;
    // Duty mode compares the count, frequency mode uses the sg_q toggle.
    assign wave = sg_mode ? s_r.sg_q : (s_r.cnt < x_val + PORT_OFFSET);

    always_comb begin
        s_nxt = s_r;
        // Ignoring ce_reset and halt here keeps every pin and waveform going.
        if (rf_req.wr && rf_req.addr == RF_PIN_MODE_ADDR) begin
            s_nxt.pmode = rf_req.wdata[3:0];
        end
        if (pa_req.wr && pa_req.addr == PA_CLOCK_PORT_ADDR && !clk_stop) begin
            s_nxt.setting = pa_req.wdata;
        end
        if (clk_stop) begin
            s_nxt.pmode = PIN_MODE_RST;
        end
        s_nxt.div = tick ? 16'h0000 : s_r.div + 16'h0001;
        if (!clock_port_en) begin
            s_nxt.cnt = 7'h00;
            s_nxt.sg_q = 1'b0;
        end else if (tick) begin
            if (s_r.cnt >= limit) begin
                s_nxt.cnt = 7'h00;
                s_nxt.sg_q = ~s_r.sg_q;
            end else begin
                s_nxt.cnt = s_r.cnt + 7'd1;
            end
        end
        for (int i = 0; i < NUM_CONV_PINS; i++) begin
            s_nxt.conv[i] = s_r.pmode[PM_CONV_LSB + i] ? conv_pwm[i]
                : port_latch[PM_CONV_LSB + i];
        end
        s_nxt.cgp_pin = (s_r.pmode[PM_CLOCK_PIN_BIT] && clock_port_en)
            ? wave : port_latch[0];
        s_nxt.rf_rdata = (rf_req.addr == RF_PIN_MODE_ADDR) ? s_r.pmode
            : 4'h0;
        s_nxt.pa_rdata = (pa_req.addr == PA_CLOCK_PORT_ADDR) ? s_r.setting
            : 8'h00;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_r.pmode <= PIN_MODE_RST;
            s_r.setting <= SETTING_RST;
            s_r.div <= 16'h0000;
            s_r.cnt <= 7'h00;
            s_r.sg_q <= 1'b0;
            s_r.conv <= 3'h0;
            s_r.cgp_pin <= 1'b0;
            s_r.rf_rdata <= 4'h0;
            s_r.pa_rdata <= 8'h00;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign conv_out = s_r.conv;
    assign clock_port_pin = s_r.cgp_pin;
    assign rf_rdata = s_r.rf_rdata;
    assign pa_rdata = s_r.pa_rdata;

    property p_por_mode;
        @(posedge mclk) sys_rst |=> s_r.pmode == 4'h0;
    endproperty
    a_por_mode: assert property (p_por_mode) else $error("mode not cleared");

    property p_stop;
        @(posedge mclk) disable iff (sys_rst)
            clk_stop |=> s_r.pmode == 4'h0 && $stable(s_r.setting);
    endproperty
    a_stop: assert property (p_stop) else $error("clock stop wrong");

    property p_standby;
        @(posedge mclk) disable iff (sys_rst)
            (ce_reset || halt) && !rf_req.wr && !clk_stop
            |=> $stable(s_r.pmode);
    endproperty
    a_standby: assert property (p_standby) else $error("standby lost mode");

    property p_gp_pin;
        @(posedge mclk) disable iff (sys_rst)
            !s_r.pmode[0] |=> clock_port_pin == $past(port_latch[0]);
    endproperty
    a_gp_pin: assert property (p_gp_pin) else $error("clock pin not latch");

    property p_conv_sel;
        @(posedge mclk) disable iff (sys_rst)
            s_r.pmode[1] |=> conv_out[0] == $past(conv_pwm[0]);
    endproperty
    a_conv_sel: assert property (p_conv_sel) else $error("conv pin wrong");

    property p_vdp;
        @(posedge mclk) disable iff (sys_rst)
            s_r.pmode[0] && clock_port_en && !sg_mode
            |=> clock_port_pin == $past(s_r.cnt < x_val + 7'd2);
    endproperty
    a_vdp: assert property (p_vdp) else $error("duty output wrong");

    property p_vdp_wrap;
        @(posedge mclk) disable iff (sys_rst)
            clock_port_en && !sg_mode && tick && s_r.cnt == 7'd66
            |=> s_r.cnt == 7'd0;
    endproperty
    a_vdp_wrap: assert property (p_vdp_wrap) else $error("period not 67");

    property p_sg;
        @(posedge mclk) disable iff (sys_rst)
            clock_port_en && sg_mode && tick && s_r.cnt == x_val + 7'd1
            |=> s_r.sg_q != $past(s_r.sg_q) && s_r.cnt == 7'd0;
    endproperty
    a_sg: assert property (p_sg) else $error("frequency divide wrong");

    property p_share;
        @(posedge mclk) disable iff (sys_rst)
            !clock_port_en |=> s_r.cnt == 7'd0 && !s_r.sg_q;
    endproperty
    a_share: assert property (p_share) else $error("counter not released");

    property p_rf_wr;
        @(posedge mclk) disable iff (sys_rst)
            rf_req.wr && rf_req.addr == 7'h13 && !clk_stop
            |=> s_r.pmode == $past(rf_req.wdata[3:0]);
    endproperty
    a_rf_wr: assert property (p_rf_wr) else $error("mode write lost");

    property p_pa_wr;
        @(posedge mclk) disable iff (sys_rst)
            pa_req.wr && pa_req.addr == 7'h20 && !clk_stop
            |=> s_r.setting == $past(pa_req.wdata);
    endproperty
    a_pa_wr: assert property (p_pa_wr) else $error("setting write lost");

    property p_tick;
        @(posedge mclk) disable iff (sys_rst)
            tick |=> !tick [*2];
    endproperty
    a_tick: assert property (p_tick) else $error("basic clock too fast");

    c_vdp: cover property (@(posedge mclk) disable iff (sys_rst)
        s_r.pmode[0] && clock_port_en && !sg_mode && tick);
    c_sg: cover property (@(posedge mclk) disable iff (sys_rst)
        s_r.pmode[0] && sg_mode && tick && s_r.cnt == 7'd0);
    c_stop: cover property (@(posedge mclk) disable iff (sys_rst)
        clk_stop && s_r.pmode != 4'h0);
endmodule // pps_pin_select

// file: rtl/pps_pkg.sv
package pps_pkg;
    // Register file and peripheral addresses.
    localparam logic [6:0] RF_PIN_MODE_ADDR = 7'h13;
    localparam logic [6:0] PA_CLOCK_PORT_ADDR = 7'h20;
    // Field positions of pin_mode_select.
    localparam int PM_CLOCK_PIN_BIT = 0;
    localparam int PM_CONV_LSB = 1;
    localparam int NUM_CONV_PINS = 3;
    // Field positions of clock_port_setting.
    localparam int SET_MODE_BIT = 0;
    localparam int SET_X_LSB = 2;
    // Reset values.
    localparam logic [3:0] PIN_MODE_RST = 4'h0;
    localparam logic [7:0] SETTING_RST = 8'h00;
    // Timing: basic clock of the port derived from the system clock.
    localparam int CLK_HZ = 250_000_000;
    localparam int PORT_BASE_HZ = 18_000;
    localparam int BASE_DIV_CYC = CLK_HZ / PORT_BASE_HZ;
    // Waveform constants.
    localparam logic [6:0] VDP_LAST_COUNT = 7'd66;
    localparam logic [6:0] PORT_OFFSET = 7'd2;

    typedef struct packed {
        logic [3:0] pmode;
        logic [7:0] setting;
        logic [15:0] div;
        logic [6:0] cnt;
        logic sg_q;
        logic [2:0] conv;
        logic cgp_pin;
        logic [3:0] rf_rdata;
        logic [7:0] pa_rdata;
    } pps_state_t;

    typedef struct packed {
        logic [6:0] addr;
        logic wr;
        logic [7:0] wdata;
    } pps_req_t;
endpackage

// file: verification/pps_pin_load.sv
`timescale 1ns/1ps
module pps_pin_load (
    // Clock and observed pin.
    input wire logic mclk,
    input wire logic pin,
    // Last high time and period, in clock cycles.
    output logic [15:0] high_len,
    output logic [15:0] per_len
);
    logic [15:0] hi_c = 16'h0000;
    logic [15:0] all_c = 16'h0000;
    logic last = 1'b0;
    initial high_len = 16'h0000;
    initial per_len = 16'h0000;
    always @(posedge mclk) begin
        last <= pin;
        if (pin && !last) begin
            high_len <= hi_c;
            per_len <= all_c;
            hi_c <= 16'h0001;
            all_c <= 16'h0001;
        end else begin
            hi_c <= hi_c + {15'h0000, pin};
            all_c <= all_c + 16'h0001;
        end
    end
endmodule // pps_pin_load

// file: verification/pwm_pin_select_and_clock_port_bench.sv
`timescale 1ns/1ps
module pwm_pin_select_and_clock_port_bench;
    import pps_pkg::*;
    logic mclk = 0, sys_rst = 1, clk_stop = 0, ce_reset = 0, halt = 0;
    logic cpe = 0, obs_go = 0, clock_port_pin;
    pps_req_t rf_req = '{RF_PIN_MODE_ADDR, 1'b0, 8'h00};
    pps_req_t pa_req = '{PA_CLOCK_PORT_ADDR, 1'b0, 8'h00};
    logic [3:0] port_latch = 4'h0, rf_rdata, m4;
    logic [2:0] conv_pwm = 3'h0, conv_out;
    logic [7:0] pa_rdata, rnd = 8'h0e;
    logic [15:0] hl, pl, got, exp_q[$];
    int sel_q[$], err_count = 0, num_checks = 0, cyc = 0;
    string nm[6] = '{"rf_rdata", "pa_rdata", "conv_out", "clock_port_pin",
                     "high_len", "per_len"};
    logic [7:0] wv[2] = '{8'hfc, 8'h01};
    logic [15:0] wh[2] = '{16'd260, 16'd8}, wp[2] = '{16'd268, 16'd16};

    pps_pin_select #(.BASE_DIV(4)) u_dut (.mclk(mclk), .sys_rst(sys_rst),
        .clk_stop(clk_stop), .ce_reset(ce_reset), .halt(halt),
        .rf_req(rf_req), .rf_rdata(rf_rdata), .pa_req(pa_req),
        .pa_rdata(pa_rdata), .clock_port_en(cpe), .port_latch(port_latch),
        .conv_pwm(conv_pwm), .conv_out(conv_out),
        .clock_port_pin(clock_port_pin));
    pps_pin_load u_load (.mclk(mclk), .pin(clock_port_pin), .high_len(hl),
        .per_len(pl));

    initial forever #2 mclk = ~mclk;

    function automatic logic [7:0] lfsr(logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic step(int n = 1);
        repeat (n) @(negedge mclk);
    endtask
    task automatic chk(int s, logic [15:0] e);
        sel_q.push_back(s);
        exp_q.push_back(e);
        obs_go = 1;
        step();
        obs_go = 0;
    endtask
    task automatic wr(bit pa, logic [7:0] d);
        if (pa) pa_req = '{PA_CLOCK_PORT_ADDR, 1'b1, d};
        else rf_req = '{RF_PIN_MODE_ADDR, 1'b1, d};
        step();
        pa_req.wr = 0;
        rf_req.wr = 0;
        step();
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            conclude();
        end
        if (obs_go) begin
            case (sel_q[0])
                0: got = {12'h000, rf_rdata};
                1: got = {8'h00, pa_rdata};
                2: got = {13'h0000, conv_out};
                3: got = {15'h0000, clock_port_pin};
                4: got = hl;
                default: got = pl;
            endcase
            num_checks++;
            if (got !== exp_q[0]) begin
                err_count++;
                $display("[FAIL] %s expected %h seen %h", nm[sel_q[0]],
                         exp_q[0], got);
            end
            void'(sel_q.pop_front());
            void'(exp_q.pop_front());
        end
    end

    initial begin
        step(16);
        sys_rst = 0;
        chk(0, 16'h0);
        chk(1, 16'h0);
        for (int m = 0; m < 16; m++) begin
            m4 = 4'(m);
            wr(0, {4'h0, m4});
            chk(0, {12'h0, m4});
            rnd = lfsr(rnd);
            port_latch = rnd[3:0];
            conv_pwm = rnd[6:4];
            step();
            chk(2, {13'h0, (m4[3:1] & conv_pwm) | (~m4[3:1] & port_latch[3:1])});
            chk(3, {15'h0, port_latch[0]});
        end
        rf_req.addr = 7'h12;
        step();
        chk(0, 16'h0);
        rf_req.addr = RF_PIN_MODE_ADDR;
        $display("test pin select done");
        cpe = 1;
        wr(0, 8'h0f);
        for (int k = 0; k < 2; k++) begin
            wr(1, wv[k]);
            chk(1, {8'h0, wv[k]});
            step(600);
            chk(4, wh[k]);
            chk(5, wp[k]);
        end
        $display("test waveforms done");
        ce_reset = 1;
        halt = 1;
        step(100);
        chk(5, 16'd16);
        chk(0, 16'hf);
        ce_reset = 0;
        halt = 0;
        clk_stop = 1;
        step();
        clk_stop = 0;
        step();
        chk(0, 16'h0);
        chk(1, 16'h01);
        chk(2, {13'h0, port_latch[3:1]});
        $display("test standby done");
        conclude();
    end
endmodule // pwm_pin_select_and_clock_port_bench
